// *** inc/ascw_map.svh ***
`ifndef ASCW_MAP_SVH
`define ASCW_MAP_SVH

// register byte offsets
`define ASCW_ADDR_W      8
`define ASCW_OFS_DAC     8'h00
`define ASCW_OFS_MUX     8'h04
`define ASCW_OFS_CTRL    8'h08
`define ASCW_OFS_STAT    8'h0c
`define ASCW_OFS_IDLE    8'h10

// field widths and positions
`define ASCW_DATA_W      32
`define ASCW_DAC_W       10
`define ASCW_POS_W       8
`define ASCW_NEG_W       3
`define ASCW_CTRL_W      13
`define ASCW_STAT_W      3
`define ASCW_POS_LSB     0
`define ASCW_NEG_LSB     8

// control register bit positions
`define ASCW_B_HOLD      0
`define ASCW_B_COMPARATOR_PRECHARGE_N     1
`define ASCW_B_SETTLE    2
`define ASCW_B_PWR       3
`define ASCW_B_GND       4
`define ASCW_B_BYPASS    5
`define ASCW_B_G10       6
`define ASCW_B_G20       7
`define ASCW_B_SWITCH_CAP_TEST_OUT    8
`define ASCW_B_IREF      9
`define ASCW_B_VCCREF    10
`define ASCW_B_PASS      11
`define ASCW_B_SCCLK     12

// status register bit positions
`define ASCW_S_COMP      0
`define ASCW_S_HOLDERR   1
`define ASCW_S_NEGERR    2

// idle (reset) values
`define ASCW_DAC_RST     10'h200
`define ASCW_POS_RST     8'h01
`define ASCW_NEG_RST     3'h0
`define ASCW_CTRL_RST    13'h0823
`define ASCW_STAT_RST    3'h0
`define ASCW_RD_ZERO     32'h0000_0000

`endif

// *** inc/ascw_pkg.sv ***
package ascw_pkg;

	// register port request from the scan controller
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ascw_bus_s;

	// every line that reaches the analog converter front end
	typedef struct packed {
		logic [9:0] dacValue;
		logic [7:0] posInputSelect;
		logic [2:0] negInputSelect;
		logic       sampleHold;
		logic       comparatorPrechargeN;
		logic       settleAssist;
		logic       gainStagePowerOn;
		logic       negativeInputGroundSel;
		logic       gainBypassSelect;
		logic       gainTenEnable;
		logic       gainTwentyEnable;
		logic       switchCapTestOut;
		logic       internalReferenceEnable;
		logic       supplyReferenceSelect;
		logic       gainPassGateEnable;
		logic       switchCapClock;
	} ascw_analog_s;

endpackage : ascw_pkg

// *** hw/ascw_control_word.sv ***
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`include "ascw_map.svh"

// Function
// - hold low tracks input, high freezes; idle high
// - precharge active low; idle high
// - ground select ties negative input to ground
// - bypass routes channels 0-3 around gain
// - switch-cap test drives x10 output to pin
// - three bits select differential negative input
// - eight low DAC value bits, idle zero
// - internal reference feeds band-gap to DAC
// - supply reference selects supply as reference
// - pass-gate enable turns on gain pass gate
// - DAC bits 9,8 idle 1,0: midpoint
module ascw_control_word
	import ascw_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire ascw_bus_s    busReq,
	output logic [31:0]       busRdata,
	input  wire logic         comparatorOut,
	output ascw_analog_s      analogCtrl,
	output logic              ch4PinOverride,
	output logic              negSourceGround
);

	// register state
	logic [`ASCW_DAC_W-1:0]  dac_ff;
	logic [`ASCW_POS_W-1:0]  posSel_ff;
	logic [`ASCW_NEG_W-1:0]  negSel_ff;
	logic [`ASCW_CTRL_W-1:0] ctrl_ff;
	logic [31:0]             rdata_ff;

	// comparator synchroniser; only the second stage feeds logic
	logic                    compSync1_ff;
	logic                    compSync2_ff;

	// hold edge tracking and sticky error flags
	logic                    holdPrev_ff;
	logic                    holdErr_ff;
	logic                    negErr_ff;

	// decoded strobes
	logic                    wrDac;
	logic                    wrMux;
	logic                    wrCtrl;
	logic                    wrStat;
	logic                    wrIdle;
	logic                    rdHit;

	// read path and error causes
	logic [31:0]             nxt_rdata;
	logic                    holdRiseLowClk;
	logic                    negConflict;
	logic [`ASCW_STAT_W-1:0] statusWord;

	// DAC write; writes and reads are never both high,
	// so each strobe looks at its own direction only
	assign wrDac  = busReq.wr && (busReq.addr == `ASCW_OFS_DAC);

	// input mux write; address is decoded exactly,
	// so aliases of a register are ignored
	assign wrMux  = busReq.wr && (busReq.addr == `ASCW_OFS_MUX);

	// control write; every strobe and enable of the
	// front end changes at once on this strobe
	assign wrCtrl = busReq.wr && (busReq.addr == `ASCW_OFS_CTRL);

	// status write; ones clear the sticky flags
	// unless their cause is present in the same cycle
	assign wrStat = busReq.wr && (busReq.addr == `ASCW_OFS_STAT);

	// idle write; the data are ignored, any write
	// restores the full idle word in one step
	assign wrIdle = busReq.wr && (busReq.addr == `ASCW_OFS_IDLE);

	// any read is taken; the address picks the data
	// and unknown places simply return zero
	assign rdHit  = busReq.rd;

	// full ten-bit DAC value; an idle write restores the midpoint
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_ff <= `ASCW_DAC_RST;
		end else if (wrIdle) begin
			dac_ff <= `ASCW_DAC_RST;
		end else if (wrDac) begin
			dac_ff <= busReq.wdata[`ASCW_DAC_W-1:0];
		end
	end

	// positive and negative input mux selects
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			posSel_ff <= `ASCW_POS_RST;
			negSel_ff <= `ASCW_NEG_RST;
		end else if (wrIdle) begin
			posSel_ff <= `ASCW_POS_RST;
			negSel_ff <= `ASCW_NEG_RST;
		end else if (wrMux) begin
			posSel_ff <= busReq.wdata[`ASCW_POS_LSB +: `ASCW_POS_W];
			negSel_ff <= busReq.wdata[`ASCW_NEG_LSB +: `ASCW_NEG_W];
		end
	end

	// strobes, enables and reference selects; idle values from reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= `ASCW_CTRL_RST;
		end else if (wrIdle) begin
			ctrl_ff <= `ASCW_CTRL_RST;
		end else if (wrCtrl) begin
			ctrl_ff <= busReq.wdata[`ASCW_CTRL_W-1:0];
		end
	end

	// comparator output comes from the analog domain: two flops first
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			compSync1_ff <= 1'h0;
			compSync2_ff <= 1'h0;
		end else begin
			compSync1_ff <= comparatorOut;
			compSync2_ff <= compSync1_ff;
		end
	end

	// previous hold level, to spot the moment the strobe rises
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			holdPrev_ff <= 1'h1;
		end else begin
			holdPrev_ff <= ctrl_ff[`ASCW_B_HOLD];
		end
	end

	// the controller owns the timing of hold against the switch-cap
	// clock; the block cannot repair a bad edge, only report it
	assign holdRiseLowClk = ctrl_ff[`ASCW_B_HOLD]
		&& !holdPrev_ff
		&& ctrl_ff[`ASCW_B_PWR]
		&& !ctrl_ff[`ASCW_B_SCCLK];

	// grounding the negative input while a pin is also selected
	// would short a pin to ground, so it is flagged
	assign negConflict = ctrl_ff[`ASCW_B_GND]
		&& (negSel_ff != `ASCW_NEG_RST);

	// sticky hold timing error; a new event beats a clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			holdErr_ff <= 1'h0;
		end else if (holdRiseLowClk) begin
			holdErr_ff <= 1'h1;
		end else if (wrStat && busReq.wdata[`ASCW_S_HOLDERR]) begin
			holdErr_ff <= 1'h0;
		end
	end

	// sticky source conflict error; a new event beats a clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			negErr_ff <= 1'h0;
		end else if (negConflict) begin
			negErr_ff <= 1'h1;
		end else if (wrStat && busReq.wdata[`ASCW_S_NEGERR]) begin
			negErr_ff <= 1'h0;
		end
	end

	// status word as seen by a read
	always_comb begin
		statusWord                 = `ASCW_STAT_RST;
		statusWord[`ASCW_S_COMP]    = compSync2_ff;
		statusWord[`ASCW_S_HOLDERR] = holdErr_ff;
		statusWord[`ASCW_S_NEGERR]  = negErr_ff;
	end

	// read mux; unmapped and write-only offsets read as zero
	always_comb begin
		nxt_rdata = `ASCW_RD_ZERO;
		if (rdHit) begin
			case (busReq.addr)
				// full ten-bit DAC value, upper bits zero
				// so a read compares directly with a write
				`ASCW_OFS_DAC: begin
					nxt_rdata[`ASCW_DAC_W-1:0] = dac_ff;
				end
				// both input selects share one word,
				// in the same places as the write
				`ASCW_OFS_MUX: begin
					nxt_rdata[`ASCW_POS_LSB +: `ASCW_POS_W] = posSel_ff;
					nxt_rdata[`ASCW_NEG_LSB +: `ASCW_NEG_W] = negSel_ff;
				end
				// control bits read back as last written
				// or as restored by reset or an idle write
				`ASCW_OFS_CTRL: begin
					nxt_rdata[`ASCW_CTRL_W-1:0] = ctrl_ff;
				end
				// status shows a flag one cycle after its
				// cause, the comparator two to three cycles late
				`ASCW_OFS_STAT: begin
					nxt_rdata[`ASCW_STAT_W-1:0] = statusWord;
				end
				// idle offset is write-only and reads zero
				// like any unmapped place
				default: begin
					nxt_rdata = `ASCW_RD_ZERO;
				end
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= `ASCW_RD_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// read data leave the block only through their register, so a read
	// never shows a value that is still settling
	assign busRdata = rdata_ff;

	// one named wire per control bit; the outputs below read by purpose
	// rather than by bit number, and a moved bit only touches the slices
	// where the register is cut apart
	logic holdLine;
	logic prechargeLineN;
	logic settleLine;
	logic powerLine;
	logic groundLine;
	logic bypassLine;
	logic gainTenLine;
	logic gainTwentyLine;
	logic testLine;
	logic internalRefLine;
	logic supplyRefLine;
	logic passGateLine;
	logic switchClockLine;

	// slices of the control register; it is the only state behind them,
	// so every line changes at the edge of the write that set it
	// and no line can glitch between two writes
	assign holdLine        = ctrl_ff[`ASCW_B_HOLD];
	assign prechargeLineN  = ctrl_ff[`ASCW_B_COMPARATOR_PRECHARGE_N];
	assign settleLine      = ctrl_ff[`ASCW_B_SETTLE];
	assign powerLine       = ctrl_ff[`ASCW_B_PWR];
	assign groundLine      = ctrl_ff[`ASCW_B_GND];
	assign bypassLine      = ctrl_ff[`ASCW_B_BYPASS];
	assign gainTenLine     = ctrl_ff[`ASCW_B_G10];
	assign gainTwentyLine  = ctrl_ff[`ASCW_B_G20];
	assign testLine        = ctrl_ff[`ASCW_B_SWITCH_CAP_TEST_OUT];
	assign internalRefLine = ctrl_ff[`ASCW_B_IREF];
	assign supplyRefLine   = ctrl_ff[`ASCW_B_VCCREF];
	assign passGateLine    = ctrl_ff[`ASCW_B_PASS];
	assign switchClockLine = ctrl_ff[`ASCW_B_SCCLK];

	// ten DAC lines: the low byte plus the two top bits,
	// idle at the midpoint of the range
	assign analogCtrl.dacValue = dac_ff;

	// positive input channel select straight from its register;
	// idle selects channel 0 only
	assign analogCtrl.posInputSelect = posSel_ff;

	// negative input select for differential measurements;
	// idle value is all zero
	assign analogCtrl.negInputSelect = negSel_ff;

	// low tracks the input, high freezes the sample;
	// idle high so a reset never leaves the converter tracking
	// while the DAC may be away from its midpoint
	assign analogCtrl.sampleHold = holdLine;

	// active low: a zero precharges the comparator latch;
	// idle high keeps the latch free, and the controller must
	// drop it for one step before each comparison
	assign analogCtrl.comparatorPrechargeN = prechargeLineN;

	// settle timing after power-on is left to the controller;
	// the block passes the line through untouched
	assign analogCtrl.settleAssist = settleLine;

	// power to the gain stages, off while idle
	// so an unused gain path draws nothing
	assign analogCtrl.gainStagePowerOn = powerLine;

	// ties the negative comparator input to ground;
	// the conflict flag watches it against the pin selects
	assign analogCtrl.negativeInputGroundSel = groundLine;

	// channels 0 to 3 take the path around the gain stages;
	// idle set, so the gain stages stay out of the way
	assign analogCtrl.gainBypassSelect = bypassLine;

	// ten times gain enable, idle off
	// since switch-cap timing is hard to meet from a scan chain
	assign analogCtrl.gainTenEnable = gainTenLine;

	// twenty times gain enable, idle off
	// for the same timing reason
	assign analogCtrl.gainTwentyEnable = gainTwentyLine;

	// switch-cap test line; while set the x10 stage output
	// leaves on the channel 4 pin, so that pin must not be driven
	// by its own port logic at the same time
	assign analogCtrl.switchCapTestOut = testLine;

	// band-gap reference feeds the DAC reference input;
	// idle off, the external reference is used
	assign analogCtrl.internalReferenceEnable = internalRefLine;

	// supply voltage as converter reference; idle off,
	// setting it together with the band-gap is the
	// controller's fault and is not repaired here
	assign analogCtrl.supplyReferenceSelect = supplyRefLine;

	// pass gate of the gain stages, on while idle
	// so the bypass path has a route to the comparator
	assign analogCtrl.gainPassGateEnable = passGateLine;

	// switch-cap clock is a register bit, so it only moves
	// as fast as the controller writes; the hold check above
	// compares against this same registered level
	assign analogCtrl.switchCapClock = switchClockLine;

	// pin of channel 4 is taken over by the x10 stage output;
	// the port logic uses this to let go of the pin
	// while the test line is set
	assign ch4PinOverride = testLine;

	// comparator negative input tied to ground; given as its own
	// port so the pin muxes can release their negative paths
	// in the same cycle
	assign negSourceGround = groundLine;

endmodule : ascw_control_word

// *** bench/ascw_control_word_sva.sv ***
`timescale 1ns/10ps
// watches the register port and the front-end lines of the control word
module ascw_control_word_sva
	import ascw_pkg::*;
(
	input wire logic         sys_clk,
	input wire logic         rst_n,
	input wire ascw_bus_s    busReq,
	input wire logic [31:0]  busRdata,
	input wire ascw_analog_s analogCtrl,
	input wire logic         ch4PinOverride,
	input wire logic         negSourceGround
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// write strobes decoded per register
	sequence ctrlWr; busReq.wr && busReq.addr == 8'h08; endsequence
	sequence dacWr; busReq.wr && busReq.addr == 8'h00; endsequence
	sequence muxWr; busReq.wr && busReq.addr == 8'h04; endsequence
	sequence idleWr; busReq.wr && busReq.addr == 8'h10; endsequence

	a_hold_write: assert property
		(ctrlWr |=> analogCtrl.sampleHold == $past(busReq.wdata[0]))
		else $error("hold line missed control write");
	a_comparator_precharge_n_write: assert property
		(ctrlWr |=> analogCtrl.comparatorPrechargeN == $past(busReq.wdata[1]))
		else $error("precharge line missed control write");
	a_bypass_write: assert property
		(ctrlWr |=> {analogCtrl.gainBypassSelect, analogCtrl.gainPassGateEnable}
			== {$past(busReq.wdata[5]), $past(busReq.wdata[11])})
		else $error("bypass or pass gate missed control write");
	a_gnd_route: assert property
		(negSourceGround == analogCtrl.negativeInputGroundSel)
		else $error("ground route differs from ground select");
	a_test_route: assert property
		(ch4PinOverride == analogCtrl.switchCapTestOut)
		else $error("channel four override differs from test line");
	a_dac_write: assert property
		(dacWr |=> analogCtrl.dacValue == $past(busReq.wdata[9:0]))
		else $error("dac lines missed write");
	a_mux_write: assert property
		(muxWr |=> {analogCtrl.negInputSelect, analogCtrl.posInputSelect}
			== $past(busReq.wdata[10:0]))
		else $error("input selects missed write");
	a_idle_word: assert property
		(idleWr |=> analogCtrl.dacValue == 10'h200 && analogCtrl.posInputSelect == 8'h01
			&& analogCtrl.sampleHold && analogCtrl.gainBypassSelect)
		else $error("idle write did not restore idle word");
	a_ref_write: assert property
		(ctrlWr |=> {analogCtrl.internalReferenceEnable, analogCtrl.supplyReferenceSelect}
			== {$past(busReq.wdata[9]), $past(busReq.wdata[10])})
		else $error("reference selects missed control write");
	a_settle_write: assert property
		(ctrlWr |=> {analogCtrl.settleAssist, analogCtrl.gainStagePowerOn}
			== {$past(busReq.wdata[2]), $past(busReq.wdata[3])})
		else $error("settle or power line missed control write");
	a_dac_read: assert property
		(busReq.rd && busReq.addr == 8'h00 |=> busRdata == {22'h0, $past(analogCtrl.dacValue)})
		else $error("dac read back wrong");
endmodule : ascw_control_word_sva

bind ascw_control_word ascw_control_word_sva i_sva (
	.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
	.analogCtrl(analogCtrl), .ch4PinOverride(ch4PinOverride),
	.negSourceGround(negSourceGround)
);

// *** bench/ascw_scan_ctrl.sv ***
`timescale 1ns/10ps
// scan controller stand-in: owns the register port and the comparator line
module ascw_scan_ctrl
	import ascw_pkg::*;
(
	input  wire logic sys_clk,
	output ascw_bus_s busReq,
	output logic      comparatorOut
);
	// quiet bus until the first request
	initial begin
		busReq = '0;
		comparatorOut = 1'b0;
	end

	// one bus cycle; strobes only drop when the next call lands, so no double drive
	task acc(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
		busReq <= '{a, d, w, r};
		@(posedge sys_clk);
	endtask : acc

	// gain stages up with settle assist on, ground off; then hold rises with clock high
	task safeHold();
		acc(8'h08, 32'h0000_180e, 1'b1, 1'b0);
		acc(8'h08, 32'h0000_180f, 1'b1, 1'b0);
	endtask : safeHold
endmodule : ascw_scan_ctrl

// *** bench/ascw_control_word_tb.sv ***
`timescale 1ns/10ps
module ascw_control_word_tb
	import ascw_pkg::*;
;
	logic         sys_clk = 1'b0;
	logic         rst_n = 1'b0;
	ascw_bus_s    busReq;
	logic [31:0]  busRdata;
	logic         comparatorOut;
	ascw_analog_s analogCtrl;
	logic         ch4PinOverride;
	logic         negSourceGround;
	logic         rdSeen = 1'b0;
	logic         cmpBit;
	logic [31:0]  expQ[$];
	logic [31:0]  r;
	int           n_errors = 0;
	int           compares = 0;
	int           cycles = 0;

	// 250 MHz
	always #2 sys_clk = ~sys_clk;

	ascw_scan_ctrl i_ctrl (.sys_clk(sys_clk), .busReq(busReq), .comparatorOut(comparatorOut));
	ascw_control_word i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
		.comparatorOut(comparatorOut), .analogCtrl(analogCtrl),
		.ch4PinOverride(ch4PinOverride), .negSourceGround(negSourceGround)
	);

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		i_ctrl.acc(a, d, 1'b1, 1'b0);
	endtask : wr

	// expected value is noted now and judged when the data show up
	task rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		i_ctrl.acc(a, 32'h0, 1'b0, 1'b1);
	endtask : rd

	task summarize();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// read data stand only the cycle after the strobe; also the hang limit
	always @(posedge sys_clk) begin
		if (rdSeen)
			chk("rdata", busRdata, expQ.pop_front());
		rdSeen <= busReq.rd;
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			summarize();
		end
	end

	initial begin
		void'($urandom(48095));
		cmpBit = 1'($urandom_range(1, 0));
		i_ctrl.comparatorOut <= cmpBit;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		// idle word, then an unmapped place that must read zero
		rd(8'h00, 32'h200);
		rd(8'h04, 32'h001);
		rd(8'h08, 32'h823);
		rd(8'h0c, {31'h0, cmpBit});
		rd(8'h14, 32'h0);
		// random words; bits above each field must be dropped
		repeat (4) begin
			r = $urandom;
			wr(8'h00, r);
			rd(8'h00, {22'h0, r[9:0]});
			wr(8'h04, r);
			rd(8'h04, {21'h0, r[10:0]});
			wr(8'h08, r);
			rd(8'h08, {19'h0, r[12:0]});
			chk("pinOvr", {31'h0, ch4PinOverride}, {31'h0, r[8]});
			chk("gndSrc", {31'h0, negSourceGround}, {31'h0, r[4]});
		end
		wr(8'h10, r);
		wr(8'h0c, 32'h6);
		rd(8'h08, 32'h823);
		rd(8'h0c, {31'h0, cmpBit});
		// hold raised while the switch-cap clock is low is flagged
		wr(8'h08, 32'h080a);
		wr(8'h08, 32'h080b);
		wr(8'h00, 32'h200);
		rd(8'h0c, {29'h0, 2'b01, cmpBit});
		wr(8'h0c, 32'h2);
		i_ctrl.safeHold();
		rd(8'h0c, {31'h0, cmpBit});
		// ground plus a pin select is a conflict; a clear cannot beat it
		wr(8'h04, 32'h100);
		wr(8'h08, 32'h0833);
		// the flag lands one cycle after its cause, so let one cycle pass
		i_ctrl.acc(8'h00, 32'h0, 1'b0, 1'b0);
		rd(8'h0c, {29'h0, 2'b10, cmpBit});
		chk("gndSrc", {31'h0, negSourceGround}, 32'h1);
		wr(8'h0c, 32'h4);
		rd(8'h0c, {29'h0, 2'b10, cmpBit});
		wr(8'h10, 32'h0);
		wr(8'h0c, 32'h6);
		rd(8'h0c, {31'h0, cmpBit});
		repeat (3) i_ctrl.acc(8'h00, 32'h0, 1'b0, 1'b0);
		summarize();
	end
endmodule : ascw_control_word_tb
